//--- core/timer8_cfg.svh
// field positions, the reset value and codes for the 8-bit timer core
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH
`define T8_BOTTOM 8'h00
`define T8_MAX 8'hFF
`define T8_RESET_BYTE 8'h00
`define T8_FLAG_OVF 0
`define T8_FLAG_CMP_A 1
`define T8_FLAG_CMP_B 2
`define T8_MODE_LO_MSB 1
`define T8_MODE_HI_BIT 3
`define T8_CS_MSB 2
`define T8_CS_STOP 3'h0
`define T8_CS_DIV1 3'h1
`define T8_CS_DIV8 3'h2
`define T8_CS_DIV64 3'h3
`define T8_CS_DIV256 3'h4
`define T8_CS_DIV1024 3'h5
`define T8_CS_EXT_FALL 3'h6
`define T8_CS_EXT_RISE 3'h7
`define T8_PRESCALE_W 10
`define T8_M_NORMAL 3'h0
`define T8_M_PC_MAX 3'h1
`define T8_M_CTC 3'h2
`define T8_M_FAST_MAX 3'h3
`define T8_M_PC_A 3'h5
`define T8_M_FAST_A 3'h7
`endif

//--- core/timer8_pkg.sv
// shared types of the 8-bit timer core
`default_nettype none
`include "timer8_cfg.svh"
package timer8_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] field3_t;
  typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} dir_e;
endpackage
`default_nettype wire

//--- core/timer8_tick_if.sv
// signals shared by the counter, the clock select and the compare unit
`default_nettype none
interface timer8_tick_if;
  import timer8_pkg::*;
  logic tick;
  byte_t count;
  byte_t cmp_a;
  byte_t cmp_b;
  logic count_written;
  logic hit_a;
  logic hit_b;
  modport clksel (output tick);
  modport cmp (input tick, input count, input cmp_a, input cmp_b, input count_written, output hit_a, output hit_b);
  modport core (input tick, output count, output cmp_a, output cmp_b, output count_written, input hit_a, input hit_b);
endinterface
`default_nettype wire

//--- core/timer8_clock_select.sv
// clock select stage: prescaled core clock or edge of the external count pin
`default_nettype none
`include "timer8_cfg.svh"
module timer8_clock_select #(
  parameter int PRE_W = `T8_PRESCALE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_reduce,
  input wire logic ext_pin,
  input wire timer8_pkg::field3_t cs,
  timer8_tick_if.clksel tif
);
  import timer8_pkg::*;
  if (PRE_W < `T8_PRESCALE_W) begin : g_chk
    $error("prescaler too narrow for the largest division");
  end
  logic [PRE_W-1:0] pre_q;
  logic ext_q;
  // true on the last core cycle of each period of 2**k
  function automatic logic period_end(input logic [PRE_W-1:0] p, input int k);
    logic r;
    r = 1'b1;
    for (int i = 0; i < k; i++) begin
      r = r & p[i];
    end
    return r;
  endfunction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pre_q <= '0;
    else if (power_reduce) pre_q <= '0;
    else pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ext_q <= 1'b0;
    else ext_q <= ext_pin;
  end
  always_comb begin
    case (cs)
      `T8_CS_DIV1: tif.tick = 1'b1;
      `T8_CS_DIV8: tif.tick = period_end(pre_q, 3);
      `T8_CS_DIV64: tif.tick = period_end(pre_q, 6);
      `T8_CS_DIV256: tif.tick = period_end(pre_q, 8);
      `T8_CS_DIV1024: tif.tick = period_end(pre_q, 10);
      `T8_CS_EXT_FALL: tif.tick = ext_q & ~ext_pin;
      `T8_CS_EXT_RISE: tif.tick = ~ext_q & ext_pin;
      default: tif.tick = 1'b0;
    endcase
    if (power_reduce) tif.tick = 1'b0;
  end
endmodule // timer8_clock_select
`default_nettype wire

//--- core/timer8_compare.sv
// compare unit: equality against both compare values with write blocking
`default_nettype none
module timer8_compare (
  input wire logic clk,
  input wire logic rst,
  timer8_tick_if.cmp tif
);
  import timer8_pkg::*;
  logic block_q;
  // held from a count write until the next tick consumes it, even if stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) block_q <= 1'b0;
    else if (tif.count_written) block_q <= 1'b1;
    else if (tif.tick) block_q <= 1'b0;
  end
  // count sampled at the tick is the value held since the previous tick
  assign tif.hit_a = tif.tick & (tif.count == tif.cmp_a) & ~block_q & ~tif.count_written;
  assign tif.hit_b = tif.tick & (tif.count == tif.cmp_b) & ~block_q & ~tif.count_written;
endmodule // timer8_compare
`default_nettype wire

//--- core/timer8_counter_core.sv
// 8-bit timer/counter core with compare units, flags and masks
`default_nettype none
`include "timer8_cfg.svh"
module timer8_counter_core (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic POWER_REDUCE,
  input wire logic EXT_COUNT_PIN,
  input wire logic COUNT_WR,
  input wire timer8_pkg::byte_t COUNT_WDATA,
  input wire logic CMP_A_WR,
  input wire timer8_pkg::byte_t CMP_A_WDATA,
  input wire logic CMP_B_WR,
  input wire timer8_pkg::byte_t CMP_B_WDATA,
  input wire logic CTRL_A_WR,
  input wire timer8_pkg::byte_t CTRL_A_WDATA,
  input wire logic CTRL_B_WR,
  input wire timer8_pkg::byte_t CTRL_B_WDATA,
  input wire logic FLAG_WR,
  input wire timer8_pkg::byte_t FLAG_WDATA,
  input wire logic MASK_WR,
  input wire timer8_pkg::byte_t MASK_WDATA,
  input wire logic OVF_SERVICED,
  input wire logic CMP_A_SERVICED,
  input wire logic CMP_B_SERVICED,
  output var timer8_pkg::byte_t COUNT_VALUE,
  output var timer8_pkg::byte_t COMPARE_VALUE_A,
  output var timer8_pkg::byte_t COMPARE_VALUE_B,
  output var timer8_pkg::byte_t CONTROL_A,
  output var timer8_pkg::byte_t CONTROL_B,
  output var timer8_pkg::byte_t FLAG_REG,
  output var timer8_pkg::byte_t MASK_REG,
  output var logic OVF_IRQ,
  output var logic CMP_A_IRQ,
  output var logic CMP_B_IRQ,
  output var logic MATCH_A,
  output var logic MATCH_B,
  output var logic AT_TOP,
  output var logic AT_BOTTOM,
  output var logic COUNT_DOWN
);
  import timer8_pkg::*;

  timer8_tick_if tif ();

  byte_t count_q;
  byte_t count_d;
  byte_t cmp_a_q;
  byte_t cmp_a_d;
  byte_t cmp_b_q;
  byte_t cmp_b_d;
  byte_t ctrl_a_q;
  byte_t ctrl_b_q;
  byte_t ctrl_b_d;
  byte_t flag_q;
  byte_t flag_d;
  byte_t mask_q;
  byte_t mask_d;
  dir_e dir_q;
  dir_e dir_d;
  field3_t mode;
  field3_t cs;
  byte_t top_val;
  logic at_top;
  logic at_bottom;
  logic ovf_set;
  byte_t flag_set;
  byte_t flag_clr;

  // mode decode used for top selection and for the counting style
  function automatic logic top_from_a(input field3_t m);
    return (m == `T8_M_CTC) || (m == `T8_M_PC_A) || (m == `T8_M_FAST_A);
  endfunction

  function automatic logic is_phase(input field3_t m);
    return (m == `T8_M_PC_MAX) || (m == `T8_M_PC_A);
  endfunction

  function automatic logic is_fast(input field3_t m);
    return (m == `T8_M_FAST_MAX) || (m == `T8_M_FAST_A);
  endfunction

  function automatic byte_t top_of(input field3_t m, input byte_t a);
    return top_from_a(m) ? a : `T8_MAX;
  endfunction

  assign mode = {ctrl_b_q[`T8_MODE_HI_BIT], ctrl_a_q[`T8_MODE_LO_MSB:0]};
  assign cs = ctrl_b_q[`T8_CS_MSB:0];
  assign top_val = top_of(mode, cmp_a_q);
  assign at_top = (count_q == top_val);
  assign at_bottom = (count_q == `T8_BOTTOM);

  assign tif.count = count_q;
  assign tif.cmp_a = cmp_a_q;
  assign tif.cmp_b = cmp_b_q;
  assign tif.count_written = COUNT_WR;

  timer8_clock_select #(
    .PRE_W(`T8_PRESCALE_W)
  ) u_clksel (
    .clk(CORE_CLK),
    .rst(RST),
    .power_reduce(POWER_REDUCE),
    .ext_pin(EXT_COUNT_PIN),
    .cs(cs),
    .tif(tif.clksel)
  );

  timer8_compare u_cmp (
    .clk(CORE_CLK),
    .rst(RST),
    .tif(tif.cmp)
  );

  // next count and direction; the processor write is applied last so it wins
  always_comb begin
    count_d = count_q;
    dir_d = dir_q;
    ovf_set = 1'b0;
    if (tif.tick) begin
      if (is_phase(mode)) begin
        if (dir_q == DIR_UP) begin
          if (at_top) begin
            dir_d = DIR_DOWN;
            count_d = count_q - 8'h01;
          end else begin
            count_d = count_q + 8'h01;
          end
        end else begin
          if (at_bottom) begin
            dir_d = DIR_UP;
            count_d = count_q + 8'h01;
            ovf_set = 1'b1;
          end else begin
            count_d = count_q - 8'h01;
          end
        end
      end else if (is_fast(mode)) begin
        dir_d = DIR_UP;
        if (at_top) begin
          count_d = `T8_BOTTOM;
          ovf_set = 1'b1;
        end else begin
          count_d = count_q + 8'h01;
        end
      end else if (mode == `T8_M_CTC) begin
        dir_d = DIR_UP;
        // overflow only when the count really passes the maximum
        ovf_set = (count_q == `T8_MAX);
        count_d = at_top ? `T8_BOTTOM : count_q + 8'h01;
      end else begin
        // normal mode; unused codes fall back to it
        dir_d = DIR_UP;
        count_d = count_q + 8'h01;
        ovf_set = (count_q == `T8_MAX);
      end
    end
    if (COUNT_WR) begin
      count_d = COUNT_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) count_q <= `T8_RESET_BYTE;
    else count_q <= count_d;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) dir_q <= DIR_UP;
    else dir_q <= dir_d;
  end

  assign cmp_a_d = CMP_A_WR ? CMP_A_WDATA : cmp_a_q;
  assign cmp_b_d = CMP_B_WR ? CMP_B_WDATA : cmp_b_q;

  // compare values are written directly; no update buffering
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cmp_a_q <= `T8_RESET_BYTE;
      cmp_b_q <= `T8_RESET_BYTE;
    end else begin
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
    end
  end

  assign ctrl_b_d = CTRL_B_WR ? CTRL_B_WDATA : ctrl_b_q;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_a_q <= `T8_RESET_BYTE;
      ctrl_b_q <= `T8_RESET_BYTE;
    end else begin
      if (CTRL_A_WR) ctrl_a_q <= CTRL_A_WDATA;
      ctrl_b_q <= ctrl_b_d;
    end
  end

  // flag set and clear terms; a set in the clearing cycle survives
  always_comb begin
    flag_set = '0;
    flag_set[`T8_FLAG_OVF] = ovf_set;
    flag_set[`T8_FLAG_CMP_A] = tif.hit_a;
    flag_set[`T8_FLAG_CMP_B] = tif.hit_b;
    flag_clr = FLAG_WR ? FLAG_WDATA : '0;
    flag_clr[`T8_FLAG_OVF] = flag_clr[`T8_FLAG_OVF] | OVF_SERVICED;
    flag_clr[`T8_FLAG_CMP_A] = flag_clr[`T8_FLAG_CMP_A] | CMP_A_SERVICED;
    flag_clr[`T8_FLAG_CMP_B] = flag_clr[`T8_FLAG_CMP_B] | CMP_B_SERVICED;
    flag_d = (flag_q & ~flag_clr) | flag_set;
    // only the three source bits exist
    flag_d[7:3] = 5'h0;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) flag_q <= `T8_RESET_BYTE;
    else flag_q <= flag_d;
  end

  assign mask_d = MASK_WR ? {5'h0, MASK_WDATA[2:0]} : mask_q;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) mask_q <= `T8_RESET_BYTE;
    else mask_q <= mask_d;
  end

  // readback copies, registered so every output leaves a flip-flop
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      COUNT_VALUE <= `T8_RESET_BYTE;
      COMPARE_VALUE_A <= `T8_RESET_BYTE;
      COMPARE_VALUE_B <= `T8_RESET_BYTE;
      CONTROL_A <= `T8_RESET_BYTE;
      CONTROL_B <= `T8_RESET_BYTE;
      FLAG_REG <= `T8_RESET_BYTE;
      MASK_REG <= `T8_RESET_BYTE;
    end else begin
      COUNT_VALUE <= count_d;
      COMPARE_VALUE_A <= cmp_a_d;
      COMPARE_VALUE_B <= cmp_b_d;
      CONTROL_A <= CTRL_A_WR ? CTRL_A_WDATA : ctrl_a_q;
      CONTROL_B <= ctrl_b_d;
      FLAG_REG <= flag_d;
      MASK_REG <= mask_d;
    end
  end

  // requests follow the next flag and mask values so they align with FLAG_REG
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      OVF_IRQ <= 1'b0;
      CMP_A_IRQ <= 1'b0;
      CMP_B_IRQ <= 1'b0;
    end else begin
      OVF_IRQ <= flag_d[`T8_FLAG_OVF] & mask_d[`T8_FLAG_OVF];
      CMP_A_IRQ <= flag_d[`T8_FLAG_CMP_A] & mask_d[`T8_FLAG_CMP_A];
      CMP_B_IRQ <= flag_d[`T8_FLAG_CMP_B] & mask_d[`T8_FLAG_CMP_B];
    end
  end

  // waveform side sees equality of the values that the counter will hold
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      MATCH_A <= 1'b1;
      MATCH_B <= 1'b1;
    end else begin
      MATCH_A <= (count_d == cmp_a_d);
      MATCH_B <= (count_d == cmp_b_d);
    end
  end

  // top uses the next mode and compare value so a change shows at once
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      AT_TOP <= 1'b0;
      AT_BOTTOM <= 1'b1;
      COUNT_DOWN <= 1'b0;
    end else begin
      AT_TOP <= (count_d == top_of({ctrl_b_d[`T8_MODE_HI_BIT],
        (CTRL_A_WR ? CTRL_A_WDATA[`T8_MODE_LO_MSB:0] : ctrl_a_q[`T8_MODE_LO_MSB:0])}, cmp_a_d));
      AT_BOTTOM <= (count_d == `T8_BOTTOM);
      COUNT_DOWN <= (dir_d == DIR_DOWN);
    end
  end

endmodule // timer8_counter_core
`default_nettype wire

//--- verif/timer8_counter_core_monitor.sv
// concurrent checks on the timer core ports
`default_nettype none
module timer8_counter_core_monitor (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic POWER_REDUCE,
  input wire logic COUNT_WR,
  input wire timer8_pkg::byte_t COUNT_WDATA,
  input wire logic FLAG_WR,
  input wire timer8_pkg::byte_t FLAG_WDATA,
  input wire logic MASK_WR,
  input wire timer8_pkg::byte_t MASK_WDATA,
  input wire logic CMP_B_SERVICED,
  input wire timer8_pkg::byte_t COUNT_VALUE,
  input wire timer8_pkg::byte_t COMPARE_VALUE_A,
  input wire timer8_pkg::byte_t COMPARE_VALUE_B,
  input wire timer8_pkg::byte_t CONTROL_A,
  input wire timer8_pkg::byte_t CONTROL_B,
  input wire timer8_pkg::byte_t FLAG_REG,
  input wire timer8_pkg::byte_t MASK_REG,
  input wire logic OVF_IRQ,
  input wire logic CMP_A_IRQ,
  input wire logic CMP_B_IRQ,
  input wire logic MATCH_A,
  input wire logic MATCH_B,
  input wire logic AT_TOP,
  input wire logic AT_BOTTOM
);
  import timer8_pkg::*;
  logic top_a;
  // modes whose top is compare value A
  assign top_a = {CONTROL_B[3], CONTROL_A[1:0]} inside {3'h2, 3'h5, 3'h7};
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // three quiet samples so a pipelined tick stage cannot leave a stale write block
  sequence s_run;
    (CONTROL_B[2:0] == 3'h1 && !POWER_REDUCE && !COUNT_WR) [*3];
  endsequence
  sequence s_normal;
    CONTROL_A[1:0] == 2'h0 && !CONTROL_B[3];
  endsequence
  a_bottom_tracks: assert property (AT_BOTTOM == (COUNT_VALUE == 8'h00)) else $error("bottom wrong");
  a_write_wins: assert property (COUNT_WR |=> COUNT_VALUE == $past(COUNT_WDATA)) else $error("write lost");
  a_stop_hold: assert property (CONTROL_B[2:0] == 3'h0 && $past(CONTROL_B[2:0]) == 3'h0 && !COUNT_WR
    |=> $stable(COUNT_VALUE)) else $error("stopped count moved");
  a_power_hold: assert property (POWER_REDUCE && $past(POWER_REDUCE) && !COUNT_WR |=> $stable(COUNT_VALUE))
    else $error("idle count moved");
  a_up_step: assert property (s_run ##0 s_normal ##0 COUNT_VALUE != 8'hFF
    |=> COUNT_VALUE == $past(COUNT_VALUE) + 8'h01) else $error("bad step");
  a_wrap_ovf: assert property (s_run ##0 s_normal ##0 COUNT_VALUE == 8'hFF
    |=> COUNT_VALUE == 8'h00 && FLAG_REG[0]) else $error("no wrap flag");
  a_match_flag: assert property (s_run ##0 MATCH_A |=> FLAG_REG[1]) else $error("match flag missing");
  a_ovf_irq: assert property (OVF_IRQ == (FLAG_REG[0] && MASK_REG[0])) else $error("ovf irq wrong");
  a_cmp_irq: assert property ({CMP_B_IRQ, CMP_A_IRQ} == (FLAG_REG[2:1] & MASK_REG[2:1]))
    else $error("cmp irq wrong");
  a_w1c_clear: assert property (FLAG_WR && FLAG_WDATA[1] && !MATCH_A |=> !FLAG_REG[1])
    else $error("flag a kept");
  a_svc_clear: assert property (CMP_B_SERVICED && !MATCH_B |=> !FLAG_REG[2]) else $error("flag b kept");
  a_mask_bits: assert property (MASK_WR |=> MASK_REG == ($past(MASK_WDATA) & 8'h07))
    else $error("mask wrong");
  a_match_tracks: assert property ({MATCH_B, MATCH_A} == {COUNT_VALUE == COMPARE_VALUE_B,
    COUNT_VALUE == COMPARE_VALUE_A}) else $error("match wrong");
  a_top_tracks: assert property (AT_TOP == (COUNT_VALUE == (top_a ? COMPARE_VALUE_A : 8'hFF)))
    else $error("top wrong");
endmodule // timer8_counter_core_monitor
bind timer8_counter_core timer8_counter_core_monitor u_mon (.CORE_CLK(CORE_CLK), .RST(RST),
  .POWER_REDUCE(POWER_REDUCE), .COUNT_WR(COUNT_WR), .COUNT_WDATA(COUNT_WDATA), .FLAG_WR(FLAG_WR),
  .FLAG_WDATA(FLAG_WDATA), .MASK_WR(MASK_WR), .MASK_WDATA(MASK_WDATA), .CMP_B_SERVICED(CMP_B_SERVICED),
  .COUNT_VALUE(COUNT_VALUE), .COMPARE_VALUE_A(COMPARE_VALUE_A), .COMPARE_VALUE_B(COMPARE_VALUE_B),
  .CONTROL_A(CONTROL_A), .CONTROL_B(CONTROL_B), .FLAG_REG(FLAG_REG),
  .MASK_REG(MASK_REG), .OVF_IRQ(OVF_IRQ), .CMP_A_IRQ(CMP_A_IRQ), .CMP_B_IRQ(CMP_B_IRQ), .MATCH_A(MATCH_A),
  .MATCH_B(MATCH_B), .AT_TOP(AT_TOP), .AT_BOTTOM(AT_BOTTOM));
`default_nettype wire

//--- verif/timer8_cpu_model.sv
// processor-side model: power-reduce control and interrupt service
`default_nettype none
module timer8_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic auto_svc,
  input wire logic [1:0] svc_delay,
  input wire logic [2:0] irq,
  output wire logic power_reduce,
  output var logic [2:0] serviced
);
  logic [1:0] wait_q;
  assign power_reduce = !enable;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 2'h0;
      serviced <= 3'h0;
    end else if (auto_svc && irq != 3'h0 && serviced == 3'h0) begin
      if (wait_q == svc_delay) begin
        // one source per visit, lowest first
        serviced <= irq & (~irq + 3'h1);
        wait_q <= 2'h0;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end else begin
      wait_q <= 2'h0;
      serviced <= 3'h0;
    end
  end
endmodule // timer8_cpu_model
`default_nettype wire

//--- verif/timer8_counter_core_test.sv
// self-checking bench for the 8-bit timer core
`default_nettype none
module timer8_counter_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import timer8_pkg::*;
  localparam int w_cnt = 0, w_ca = 1, w_cb = 2, w_ta = 3, w_tb = 4, w_fl = 5, w_mk = 6;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic pin = 1'b0;
  logic en = 1'b0;
  logic asvc = 1'b0;
  logic pwr, bot, down;
  logic [6:0] wr = 7'h00;
  logic [2:0] svc, irq;
  byte_t wd [7] = '{default: 8'h00};
  byte_t rd [7];
  int n_fail = 0;
  int num_checks = 0;
  timer8_counter_core dut (.CORE_CLK(CORE_CLK), .RST(RST), .POWER_REDUCE(pwr), .EXT_COUNT_PIN(pin),
    .COUNT_WR(wr[0]), .COUNT_WDATA(wd[0]), .CMP_A_WR(wr[1]), .CMP_A_WDATA(wd[1]), .CMP_B_WR(wr[2]),
    .CMP_B_WDATA(wd[2]), .CTRL_A_WR(wr[3]), .CTRL_A_WDATA(wd[3]), .CTRL_B_WR(wr[4]), .CTRL_B_WDATA(wd[4]),
    .FLAG_WR(wr[5]), .FLAG_WDATA(wd[5]), .MASK_WR(wr[6]), .MASK_WDATA(wd[6]), .OVF_SERVICED(svc[0]),
    .CMP_A_SERVICED(svc[1]), .CMP_B_SERVICED(svc[2]), .COUNT_VALUE(rd[0]), .COMPARE_VALUE_A(rd[1]),
    .COMPARE_VALUE_B(rd[2]), .CONTROL_A(rd[3]), .CONTROL_B(rd[4]), .FLAG_REG(rd[5]), .MASK_REG(rd[6]),
    .OVF_IRQ(irq[0]), .CMP_A_IRQ(irq[1]), .CMP_B_IRQ(irq[2]), .MATCH_A(), .MATCH_B(), .AT_TOP(),
    .AT_BOTTOM(bot), .COUNT_DOWN(down));
  timer8_cpu_model cpu (.clk(CORE_CLK), .rst(RST), .enable(en), .auto_svc(asvc), .svc_delay(2'h3),
    .irq(irq), .power_reduce(pwr), .serviced(svc));
  always #5 CORE_CLK = ~CORE_CLK;
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic wr_reg(input int i, input byte_t d);
    @(posedge CORE_CLK);
    wr[i] <= 1'b1;
    wd[i] <= d;
    @(posedge CORE_CLK);
    wr[i] <= 1'b0;
    #1;
  endtask
  // cs stays selected for exactly n+2 edges, which gives n+2 ticks for cs 1
  task automatic run(input byte_t cs, input int n);
    wr_reg(w_tb, cs);
    cyc(n);
    wr_reg(w_tb, 8'h00);
  endtask
  task automatic pulse;
    @(posedge CORE_CLK);
    pin <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    pin <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic chk(input byte_t got, input byte_t exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic t_basic;
    int sh [5] = '{0, 3, 6, 8, 10};
    for (int i = 0; i < 7; i++) begin
      chk(rd[i], 8'h00);
    end
    chk({7'h00, bot}, 8'h01);
    wr_reg(w_ca, 8'hA5);
    wr_reg(w_cb, 8'hFF);
    wr_reg(w_cnt, 8'h3C);
    chk(rd[1], 8'hA5);
    chk(rd[2], 8'hFF);
    chk(rd[0], 8'h3C);
    wr_reg(w_mk, 8'hFF);
    chk(rd[6], 8'h07);
    wr_reg(w_tb, 8'hF8);
    chk(rd[4], 8'hF8);
    cyc(20);
    chk(rd[0], 8'h3C);
    for (int k = 0; k < 5; k++) begin
      wr_reg(w_cnt, 8'h00);
      run(byte_t'(k + 1), (2 << sh[k]) - 2);
      chk(rd[0], 8'h02);
    end
    $display("basic and prescale test done");
  endtask
  task automatic t_ext;
    wr_reg(w_cnt, 8'h00);
    wr_reg(w_tb, 8'h07);
    repeat (3) pulse();
    chk(rd[0], 8'h03);
    wr_reg(w_tb, 8'h06);
    repeat (3) pulse();
    wr_reg(w_tb, 8'h00);
    chk(rd[0], 8'h06);
    wr_reg(w_tb, 8'h01);
    wr_reg(w_cnt, 8'h40);
    chk(rd[0], 8'h40);
    cyc(1);
    chk(rd[0], 8'h41);
    wr_reg(w_tb, 8'h00);
    $display("edge and priority test done");
  endtask
  task automatic t_match;
    wr_reg(w_cnt, 8'h20);
    wr_reg(w_ca, 8'h20);
    wr_reg(w_fl, 8'h07);
    chk(rd[5], 8'h00);
    run(8'h01, 4);
    chk(rd[5] & 8'h02, 8'h00);
    wr_reg(w_tb, 8'h01);
    wr_reg(w_cnt, 8'h1E);
    cyc(2);
    chk(rd[5] & 8'h02, 8'h00);
    cyc(1);
    chk(rd[0], 8'h21);
    chk(rd[5] & 8'h02, 8'h02);
    chk({7'h00, irq[1]}, 8'h01);
    wr_reg(w_fl, 8'h02);
    chk(rd[5] & 8'h02, 8'h00);
    wr_reg(w_tb, 8'h00);
    $display("compare test done");
  endtask
  task automatic t_wrap;
    wr_reg(w_mk, 8'h01);
    wr_reg(w_fl, 8'h07);
    wr_reg(w_cnt, 8'hFD);
    run(8'h01, 2);
    chk(rd[0], 8'h01);
    chk(rd[5], 8'h05);
    chk({5'h00, irq}, 8'h01);
    wr_reg(w_mk, 8'h07);
    @(posedge CORE_CLK);
    asvc <= 1'b1;
    for (int i = 0; i < 40 && rd[5] !== 8'h00; i++) begin
      cyc(1);
    end
    chk(rd[5], 8'h00);
    if (rd[5] !== 8'h00) begin
      wrap_up();
    end
    @(posedge CORE_CLK);
    asvc <= 1'b0;
    $display("overflow and service test done");
  endtask
  task automatic t_modes;
    wr_reg(w_cnt, 8'h00);
    wr_reg(w_ta, 8'h02);
    chk(rd[3], 8'h02);
    wr_reg(w_ca, 8'h03);
    run(8'h01, 2);
    chk(rd[0], 8'h00);
    wr_reg(w_ta, 8'h01);
    wr_reg(w_cnt, 8'hFD);
    run(8'h01, 2);
    chk(rd[0], 8'hFD);
    chk({7'h00, down}, 8'h01);
    wr_reg(w_fl, 8'h07);
    wr_reg(w_ta, 8'h03);
    wr_reg(w_ca, 8'h04);
    wr_reg(w_cnt, 8'hFE);
    run(8'h01, 1);
    chk(rd[0], 8'h01);
    chk(rd[5] & 8'h01, 8'h01);
    wr_reg(w_fl, 8'h07);
    wr_reg(w_cnt, 8'h02);
    // bit 3 of control B lifts the phase-correct and fast modes to their compare-A variants
    run(8'h09, 1);
    chk(rd[0], 8'h00);
    chk(rd[5] & 8'h01, 8'h01);
    wr_reg(w_fl, 8'h07);
    wr_reg(w_ta, 8'h01);
    wr_reg(w_cnt, 8'h03);
    run(8'h09, 4);
    chk(rd[0], 8'h01);
    chk(rd[5] & 8'h01, 8'h01);
    chk({7'h00, down}, 8'h00);
    wr_reg(w_ta, 8'h00);
    @(posedge CORE_CLK);
    en <= 1'b0;
    wr_reg(w_cnt, 8'h11);
    run(8'h01, 8);
    chk(rd[0], 8'h11);
    @(posedge CORE_CLK);
    en <= 1'b1;
    $display("mode and power test done");
  endtask
  initial begin
    repeat (16) @(posedge CORE_CLK);
    RST <= 1'b0;
    en <= 1'b1;
    cyc(1);
    t_basic();
    t_ext();
    t_match();
    t_wrap();
    t_modes();
    wrap_up();
  end
endmodule // timer8_counter_core_test
`default_nettype wire
